/* prb_defines.svh */
// constants for the root port bridge control register bank
`ifndef PRB_DEFINES_SVH
`define PRB_DEFINES_SVH

// register byte offsets in configuration space
`define PRB_OFF_INT_PIN 8'h3d
`define PRB_OFF_BRIDGE_CTRL 8'h3e
`define PRB_OFF_HOT_SWAP_CMD 8'h44
`define PRB_OFF_VENDOR_CMD 8'h45
`define PRB_OFF_HOT_SWAP_STS 8'h46
`define PRB_OFF_PORT_STS 8'h47

// reset values
`define PRB_RST_INT_PIN 8'h02
`define PRB_RST_ZERO 8'h00

// interrupt pin encodings
`define PRB_PIN_INTA 8'h01
`define PRB_PIN_INTD 8'h04

// bridge control bit positions
`define PRB_BC_POISON_EN 0
`define PRB_BC_ERR_FWD_EN 1
`define PRB_BC_IO_ALIAS 2
`define PRB_BC_VIDEO_EN 3
`define PRB_BC_HOT_RESET 6

// vendor command bit positions
`define PRB_VC_PWR_OFF_REQ 0
`define PRB_VC_LOOPBACK 1
`define PRB_VC_HS_ROUTE 2
`define PRB_VC_CPL_TO_DIS 3

// port status bit positions
`define PRB_PS_PWR_OFF_ACK 0
`define PRB_PS_LINK_ACTIVE 1

// legacy video ranges
`define PRB_VGA_MEM_LO 32'h000a0000
`define PRB_VGA_MEM_HI 32'h000bffff
`define PRB_VGA_IO0_LO 16'h03b0
`define PRB_VGA_IO0_HI 16'h03bb
`define PRB_VGA_IO1_LO 16'h03c0
`define PRB_VGA_IO1_HI 16'h03df

// alias field of an i/o address: nonzero means last 768 bytes of a 1-KB block
`define PRB_ALIAS_MSB 9
`define PRB_ALIAS_LSB 8
`define PRB_ALIAS_NONE 2'h0

`endif

/* prb_pkg.sv */
// types shared by the root port bridge control block
package prb_pkg;

  typedef logic [7:0] prb_byte_t;

  // downstream hot reset sequencing
  typedef enum logic [1:0] {
    PRB_HR_IDLE,
    PRB_HR_ACTIVE,
    PRB_HR_DRAIN,
    PRB_HR_DETECT
  } prb_hr_state_e;

endpackage : prb_pkg

/* prb_io_route.sv */
// processor transaction routing between pci express and the legacy hub link
`timescale 1ns/1ns
`default_nettype none
`include "prb_defines.svh"

module prb_io_route (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic legacy_video_route_en,
  input wire logic legacy_io_alias_block,
  input wire logic cpu_req,
  input wire logic cpu_is_io,
  input wire logic [31:0] cpu_addr,
  input wire logic [15:0] io_window_base,
  input wire logic [15:0] io_window_limit,
  output logic route_valid,
  output logic route_pcie,
  output logic route_hub
);

  logic io_in_window;
  logic io_alias_hit;
  logic vga_hit;
  logic to_pcie;

  // decode of the current request
  assign io_in_window = cpu_is_io && (cpu_addr[15:0] >= io_window_base) && (cpu_addr[15:0] <= io_window_limit);
  assign io_alias_hit = cpu_addr[`PRB_ALIAS_MSB:`PRB_ALIAS_LSB] != `PRB_ALIAS_NONE;
  assign vga_hit = legacy_video_route_en &&
    (cpu_is_io ? ((cpu_addr[15:0] >= `PRB_VGA_IO0_LO && cpu_addr[15:0] <= `PRB_VGA_IO0_HI) ||
                  (cpu_addr[15:0] >= `PRB_VGA_IO1_LO && cpu_addr[15:0] <= `PRB_VGA_IO1_HI))
               : (cpu_addr >= `PRB_VGA_MEM_LO && cpu_addr <= `PRB_VGA_MEM_HI));
  // video routing wins over the alias block, since vga i/o sits in the alias area
  assign to_pcie = vga_hit || (io_in_window && !(legacy_io_alias_block && io_alias_hit));

  // registered routing decision, one cycle after the request
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      route_valid <= 1'b0;
      route_pcie <= 1'b0;
      route_hub <= 1'b0;
    end else begin
      route_valid <= cpu_req;
      route_pcie <= cpu_req && to_pcie;
      route_hub <= cpu_req && !to_pcie;
    end
  end

endmodule : prb_io_route
`default_nettype wire

/* prb_err_fwd.sv */
// error message forwarding and hot-swap event steering
`timescale 1ns/1ns
`default_nettype none
`include "prb_defines.svh"

module prb_err_fwd (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic error_msg_forward_en,
  input wire logic poison_report_en,
  input wire logic hot_swap_route_intx,
  input wire logic serr_msg_in,
  input wire logic poison_tlp_in,
  input wire logic other_err_in,
  input wire logic hot_swap_event,
  output logic hub_serr,
  output logic hot_swap_gpe,
  output logic hot_swap_intx
);

  // forward gate; poison needs both enables, other errors ignore the poison bit
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hub_serr <= 1'b0;
    end else begin
      hub_serr <= error_msg_forward_en &&
        (serr_msg_in || other_err_in ||
         (poison_tlp_in && poison_report_en));
    end
  end

  // hot-swap steering depends on the route bit only, no throttle or injection term
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hot_swap_gpe <= 1'b0;
      hot_swap_intx <= 1'b0;
    end else begin
      hot_swap_gpe <= hot_swap_event && !hot_swap_route_intx;
      hot_swap_intx <= hot_swap_event && hot_swap_route_intx;
    end
  end

endmodule : prb_err_fwd
`default_nettype wire

/* prb_bridge_ctrl.sv */
// root port bridge control register bank with hot reset and power-off sequencing
`timescale 1ns/1ns
`default_nettype none
`include "prb_defines.svh"

////////////////////////////////////////////////////////////////////////////////
module prb_bridge_ctrl
  import prb_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  output logic [7:0] cfg_rdata,
  input wire logic dl_down,
  input wire logic link_active,
  input wire logic tx_min_met,
  input wire logic power_off_ack_in,
  output logic ltssm_hot_reset,
  output logic ltssm_enter_detect,
  output logic power_off_send,
  output logic ts_loopback_en,
  output logic cpl_timeout_run,
  output logic [3:0] intx_pin_onehot,
  input wire logic cpu_req,
  input wire logic cpu_is_io,
  input wire logic [31:0] cpu_addr,
  input wire logic [15:0] io_window_base,
  input wire logic [15:0] io_window_limit,
  output logic route_valid,
  output logic route_pcie,
  output logic route_hub,
  input wire logic serr_msg_in,
  input wire logic poison_tlp_in,
  input wire logic other_err_in,
  input wire logic hot_swap_event,
  output logic hub_serr,
  output logic hot_swap_gpe,
  output logic hot_swap_intx
);

  ////////////////////////////////////////////////////////////////////////////////
  // register state

  prb_byte_t interrupt_pin_select;
  logic pin_locked;
  logic downstream_hot_reset;
  logic legacy_video_route_en;
  logic legacy_io_alias_block;
  logic error_msg_forward_en;
  logic poison_report_en;
  logic hot_swap_route_intx;
  logic power_off_request;
  logic power_off_ack;
  prb_hr_state_e hr_state;
  prb_hr_state_e next_hr_state;
  prb_byte_t bridge_control;
  prb_byte_t port_vendor_command;
  prb_byte_t port_status;
  prb_byte_t next_rdata;
  logic wr_pin;
  logic wr_bc;
  logic wr_vc;
  logic wr_ps;
  logic pin_code_ok;
  logic req_set;
  logic ack_set;

  // write decode
  assign wr_pin = cfg_wr && (cfg_addr == `PRB_OFF_INT_PIN);
  assign wr_bc = cfg_wr && (cfg_addr == `PRB_OFF_BRIDGE_CTRL);
  assign wr_vc = cfg_wr && (cfg_addr == `PRB_OFF_VENDOR_CMD);
  assign wr_ps = cfg_wr && (cfg_addr == `PRB_OFF_PORT_STS);
  assign pin_code_ok = (cfg_wdata >= `PRB_PIN_INTA) && (cfg_wdata <= `PRB_PIN_INTD);

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt pin selector

  // a reserved code is dropped and does not use up the single write
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      interrupt_pin_select <= `PRB_RST_INT_PIN;
      pin_locked <= 1'b0;
    end else if (wr_pin && !pin_locked && pin_code_ok) begin
      interrupt_pin_select <= cfg_wdata;
      pin_locked <= 1'b1;
    end
  end

  // one-hot pin select toward the interrupt logic
  // only coded pins are ever stored, so at most one of these flops is high
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          intx_pin_onehot[gi] <= 1'b0;
        end else begin
          intx_pin_onehot[gi] <= interrupt_pin_select == (`PRB_PIN_INTA + 8'(gi));
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // bridge control

  // only reset_n clears these; the hot reset sequence never touches them
  // bits 7, 5 and 4 have no storage, so writes to them are simply lost
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      downstream_hot_reset <= 1'b0;
      legacy_video_route_en <= 1'b0;
      legacy_io_alias_block <= 1'b0;
      error_msg_forward_en <= 1'b0;
      poison_report_en <= 1'b0;
    end else if (wr_bc) begin
      downstream_hot_reset <= cfg_wdata[`PRB_BC_HOT_RESET];
      legacy_video_route_en <= cfg_wdata[`PRB_BC_VIDEO_EN];
      legacy_io_alias_block <= cfg_wdata[`PRB_BC_IO_ALIAS];
      error_msg_forward_en <= cfg_wdata[`PRB_BC_ERR_FWD_EN];
      poison_report_en <= cfg_wdata[`PRB_BC_POISON_EN];
    end
  end

  // readback: fast back-to-back, master abort and bit 4 stay zero
  always_comb begin
    bridge_control = `PRB_RST_ZERO;
    bridge_control[`PRB_BC_HOT_RESET] = downstream_hot_reset;
    bridge_control[`PRB_BC_VIDEO_EN] = legacy_video_route_en;
    bridge_control[`PRB_BC_IO_ALIAS] = legacy_io_alias_block;
    bridge_control[`PRB_BC_ERR_FWD_EN] = error_msg_forward_en;
    bridge_control[`PRB_BC_POISON_EN] = poison_report_en;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // downstream hot reset sequence

  // reset held while the bit is set and until the minimum transmission is done
  // tx_min_met seen while the bit is still set is ignored; the partner repeats it in drain
  always_comb begin
    next_hr_state = hr_state;
    case (hr_state)
      PRB_HR_IDLE: begin
        if (downstream_hot_reset) begin
          next_hr_state = PRB_HR_ACTIVE;
        end
      end
      PRB_HR_ACTIVE: begin
        if (!downstream_hot_reset) begin
          next_hr_state = PRB_HR_DRAIN;
        end
      end
      PRB_HR_DRAIN: begin
        if (downstream_hot_reset) begin
          next_hr_state = PRB_HR_ACTIVE;
        end else if (tx_min_met) begin
          next_hr_state = PRB_HR_DETECT;
        end
      end
      PRB_HR_DETECT: begin
        next_hr_state = downstream_hot_reset ? PRB_HR_ACTIVE : PRB_HR_IDLE;
      end
      default: begin
        next_hr_state = PRB_HR_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hr_state <= PRB_HR_IDLE;
    end else begin
      hr_state <= next_hr_state;
    end
  end

  // link-side controls registered from the next state so they track it exactly
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ltssm_hot_reset <= 1'b0;
      ltssm_enter_detect <= 1'b0;
    end else begin
      ltssm_hot_reset <= (next_hr_state == PRB_HR_ACTIVE) || (next_hr_state == PRB_HR_DRAIN);
      ltssm_enter_detect <= next_hr_state == PRB_HR_DETECT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // vendor command

  // timer flag stored as run, so the output is the flop itself
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpl_timeout_run <= 1'b1;
      hot_swap_route_intx <= 1'b0;
      ts_loopback_en <= 1'b0;
    end else if (wr_vc) begin
      cpl_timeout_run <= !cfg_wdata[`PRB_VC_CPL_TO_DIS];
      hot_swap_route_intx <= cfg_wdata[`PRB_VC_HS_ROUTE];
      ts_loopback_en <= cfg_wdata[`PRB_VC_LOOPBACK];
    end
  end

  // power-off request: a new write wins over a same-cycle ack, link down wins over all
  // the request bit doubles as the pending flag, so an ack with nothing pending is dropped
  assign req_set = wr_vc && cfg_wdata[`PRB_VC_PWR_OFF_REQ];
  assign ack_set = power_off_request && power_off_ack_in;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      power_off_request <= 1'b0;
    end else if (dl_down) begin
      power_off_request <= 1'b0;
    end else if (req_set) begin
      power_off_request <= 1'b1;
    end else if (ack_set) begin
      power_off_request <= 1'b0;
    end
  end

  // one message pulse per rising request; a rewrite while pending sends nothing
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      power_off_send <= 1'b0;
    end else begin
      power_off_send <= req_set && !dl_down && !power_off_request;
    end
  end

  // ack status: set beats a same-cycle software clear
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      power_off_ack <= 1'b0;
    end else if (dl_down) begin
      power_off_ack <= 1'b0;
    end else if (ack_set) begin
      power_off_ack <= 1'b1;
    end else if (wr_ps && cfg_wdata[`PRB_PS_PWR_OFF_ACK]) begin
      power_off_ack <= 1'b0;
    end
  end

  always_comb begin
    port_vendor_command = `PRB_RST_ZERO;
    port_vendor_command[`PRB_VC_CPL_TO_DIS] = !cpl_timeout_run;
    port_vendor_command[`PRB_VC_HS_ROUTE] = hot_swap_route_intx;
    port_vendor_command[`PRB_VC_LOOPBACK] = ts_loopback_en;
    port_vendor_command[`PRB_VC_PWR_OFF_REQ] = power_off_request;
    port_status = `PRB_RST_ZERO;
    port_status[`PRB_PS_LINK_ACTIVE] = link_active;
    port_status[`PRB_PS_PWR_OFF_ACK] = power_off_ack;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path

  // hot-swap registers and unmapped offsets answer zero
  // the hot-swap command and status registers are not built, so they are named here only to keep them zero
  always_comb begin
    next_rdata = `PRB_RST_ZERO;
    case (cfg_addr)
      `PRB_OFF_INT_PIN: next_rdata = interrupt_pin_select;
      `PRB_OFF_BRIDGE_CTRL: next_rdata = bridge_control;
      `PRB_OFF_HOT_SWAP_CMD: next_rdata = `PRB_RST_ZERO;
      `PRB_OFF_VENDOR_CMD: next_rdata = port_vendor_command;
      `PRB_OFF_HOT_SWAP_STS: next_rdata = `PRB_RST_ZERO;
      `PRB_OFF_PORT_STS: next_rdata = port_status;
      default: next_rdata = `PRB_RST_ZERO;
    endcase
  end

  // data valid only in the cycle after the strobe, zero otherwise
  // the zero between reads keeps stale data off the bus for a master that samples late
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rdata <= `PRB_RST_ZERO;
    end else begin
      cfg_rdata <= cfg_rd ? next_rdata : `PRB_RST_ZERO;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // routing and error forwarding
  // both submodules only read the control bits above and register their own results

  prb_io_route u_io_route (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .legacy_video_route_en(legacy_video_route_en),
    .legacy_io_alias_block(legacy_io_alias_block),
    .cpu_req(cpu_req),
    .cpu_is_io(cpu_is_io),
    .cpu_addr(cpu_addr),
    .io_window_base(io_window_base),
    .io_window_limit(io_window_limit),
    .route_valid(route_valid),
    .route_pcie(route_pcie),
    .route_hub(route_hub)
  );

  prb_err_fwd u_err_fwd (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .error_msg_forward_en(error_msg_forward_en),
    .poison_report_en(poison_report_en),
    .hot_swap_route_intx(hot_swap_route_intx),
    .serr_msg_in(serr_msg_in),
    .poison_tlp_in(poison_tlp_in),
    .other_err_in(other_err_in),
    .hot_swap_event(hot_swap_event),
    .hub_serr(hub_serr),
    .hot_swap_gpe(hot_swap_gpe),
    .hot_swap_intx(hot_swap_intx)
  );

endmodule : prb_bridge_ctrl
`default_nettype wire

/* prb_bridge_ctrl_assertions.sv */
// concurrent checks on the ports of the bridge control register bank
`timescale 1ns/1ns
`default_nettype none

module prb_bridge_ctrl_assertions (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_rdata,
  input wire logic dl_down,
  input wire logic tx_min_met,
  input wire logic ltssm_hot_reset,
  input wire logic ltssm_enter_detect,
  input wire logic power_off_send,
  input wire logic ts_loopback_en,
  input wire logic cpl_timeout_run,
  input wire logic [3:0] intx_pin_onehot,
  input wire logic cpu_req,
  input wire logic route_valid,
  input wire logic route_pcie,
  input wire logic route_hub,
  input wire logic serr_msg_in,
  input wire logic poison_tlp_in,
  input wire logic other_err_in,
  input wire logic hot_swap_event,
  input wire logic hub_serr,
  input wire logic hot_swap_gpe,
  input wire logic hot_swap_intx
);
  logic [7:0] wdata_q;
  logic pwr_wr_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  // helper: remember last write data and a legal power-off request write
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      wdata_q <= 8'h00;
      pwr_wr_q <= 1'b0;
    end else begin
      wdata_q <= cfg_wdata;
      pwr_wr_q <= cfg_wr && cfg_addr == 8'h45 && cfg_wdata[0] && !dl_down;
    end
  end

  sequence s_hr_set;
    cfg_wr && cfg_addr == 8'h3e && cfg_wdata[6];
  endsequence
  sequence s_vc_wr;
    cfg_wr && cfg_addr == 8'h45;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!$past(cfg_rd) |-> cfg_rdata == 8'h00)
    else $error("read data driven outside the read slot");
  a_hot_reset_start: assert property (s_hr_set |-> ##2 ltssm_hot_reset)
    else $error("hot reset not raised two cycles after the write");
  a_detect_cause: assert property (ltssm_enter_detect |-> $past(ltssm_hot_reset) && $past(tx_min_met)
    && !ltssm_hot_reset) else $error("detect entry without finished hot reset");
  a_detect_pulse: assert property (ltssm_enter_detect |=> !ltssm_enter_detect)
    else $error("detect entry longer than one cycle");
  a_power_off_send: assert property (power_off_send |-> pwr_wr_q ##1 !power_off_send)
    else $error("turn off request without a request write");
  a_route_once: assert property (route_valid == $past(cpu_req) && (route_pcie || route_hub) == route_valid
    && !(route_pcie && route_hub)) else $error("routing result malformed");
  a_serr_cause: assert property (hub_serr |-> $past(serr_msg_in) || $past(other_err_in) || $past(poison_tlp_in))
    else $error("hub error without a received error");
  a_hot_swap_steer: assert property ((hot_swap_gpe || hot_swap_intx) == $past(hot_swap_event)
    && !(hot_swap_gpe && hot_swap_intx)) else $error("hot swap event steered wrongly");
  a_loopback_bit: assert property (s_vc_wr |=> ts_loopback_en == wdata_q[1])
    else $error("loopback output does not follow the written bit");
  a_cpl_timer_bit: assert property (s_vc_wr |=> cpl_timeout_run == !wdata_q[3])
    else $error("completion timer run does not follow the disable bit");
  a_pin_onehot: assert property ($onehot0(intx_pin_onehot))
    else $error("interrupt pin decode not one-hot");
endmodule : prb_bridge_ctrl_assertions

`default_nettype wire

/* prb_link_model.sv */
// downstream link partner: turn-off acknowledge and hot reset training time
`timescale 1ns/1ns
`default_nettype none

module prb_link_model #(
  parameter int MIN_TX = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic power_off_send,
  input wire logic ltssm_hot_reset,
  input wire logic [7:0] ack_delay,
  output logic power_off_ack_in,
  output logic tx_min_met
);
  logic [7:0] ack_cnt;
  logic [7:0] hr_cnt;

  // acknowledge a turn-off request after a bench-chosen delay, at least 1
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ack_cnt <= 8'h00;
      power_off_ack_in <= 1'b0;
    end else begin
      power_off_ack_in <= ack_cnt == 8'h01;
      if (power_off_send) begin
        ack_cnt <= ack_delay;
      end else if (ack_cnt != 8'h00) begin
        ack_cnt <= ack_cnt - 8'h01;
      end
    end
  end

  // training time counts only while hot reset is held on the link
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      hr_cnt <= 8'h00;
    end else if (!ltssm_hot_reset) begin
      hr_cnt <= 8'h00;
    end else if (hr_cnt != 8'(MIN_TX)) begin
      hr_cnt <= hr_cnt + 8'h01;
    end
  end
  assign tx_min_met = hr_cnt == 8'(MIN_TX);
endmodule : prb_link_model

`default_nettype wire

/* tb_top.sv */
// self-checking bench for the bridge control register bank
`timescale 1ns/1ns
`default_nettype none
`include "prb_defines.svh"

module tb_top;
  logic core_clk = 1'b0, reset_n = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, dl_down = 1'b0, link_active = 1'b1;
  logic cpu_req = 1'b0, cpu_is_io = 1'b0, serr_msg_in = 1'b0, poison_tlp_in = 1'b0;
  logic other_err_in = 1'b0, hot_swap_event = 1'b0;
  logic [7:0] cfg_addr = 8'h00, cfg_wdata = 8'h00, ack_delay = 8'h03, cfg_rdata, bc, vc, e;
  logic [31:0] cpu_addr = 32'h0, r, a;
  logic [15:0] io_window_base = 16'h0, io_window_limit = 16'h0, b;
  logic tx_min_met, power_off_ack_in, ltssm_hot_reset, ltssm_enter_detect, power_off_send, ts_loopback_en;
  logic cpl_timeout_run, route_valid, route_pcie, route_hub, hub_serr, hot_swap_gpe, hot_swap_intx, p;
  logic [3:0] intx_pin_onehot;
  logic [7:0] ro [3] = '{8'h44, 8'h46, 8'h50};
  logic [7:0] pw [4] = '{8'h00, 8'h05, 8'h04, 8'h01};
  logic [7:0] pe [4] = '{8'h02, 8'h02, 8'h04, 8'h04};
  integer seed = 36, n_mismatch = 0, samples_checked = 0, i, k;

  always #4 core_clk = ~core_clk;

  prb_bridge_ctrl dut (.core_clk, .reset_n, .cfg_addr, .cfg_wdata, .cfg_wr, .cfg_rd, .cfg_rdata, .dl_down,
    .link_active, .tx_min_met, .power_off_ack_in, .ltssm_hot_reset, .ltssm_enter_detect, .power_off_send,
    .ts_loopback_en, .cpl_timeout_run, .intx_pin_onehot, .cpu_req, .cpu_is_io, .cpu_addr, .io_window_base,
    .io_window_limit, .route_valid, .route_pcie, .route_hub, .serr_msg_in, .poison_tlp_in, .other_err_in,
    .hot_swap_event, .hub_serr, .hot_swap_gpe, .hot_swap_intx);
  prb_link_model link (.core_clk, .reset_n, .power_off_send, .ltssm_hot_reset, .ack_delay, .power_off_ack_in,
    .tx_min_met);

  ////////////////////////////////////////////////////////////////////////////
  // compare, bus cycles and expected routing
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h, expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge core_clk);
    cfg_wr <= 1'b1;
    cfg_addr <= ad;
    cfg_wdata <= d;
    @(posedge core_clk);
    cfg_wr <= 1'b0;
  endtask : wr

  // read data is only valid in the single cycle after the strobe
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge core_clk);
    cfg_rd <= 1'b1;
    cfg_addr <= ad;
    @(posedge core_clk);
    cfg_rd <= 1'b0;
    #1;
    chk(cfg_rdata, exp);
  endtask : rd

  function automatic logic exp_pcie(input logic io, input logic [31:0] ad, input logic [7:0] c,
    input logic [15:0] lo, input logic [15:0] hi);
    logic vh;
    vh = c[3] && (io ? ((ad[15:0] >= `PRB_VGA_IO0_LO && ad[15:0] <= `PRB_VGA_IO0_HI) ||
      (ad[15:0] >= `PRB_VGA_IO1_LO && ad[15:0] <= `PRB_VGA_IO1_HI)) : (ad >= `PRB_VGA_MEM_LO && ad <= `PRB_VGA_MEM_HI));
    return vh || (io && ad[15:0] >= lo && ad[15:0] <= hi && !(c[2] && ad[9:8] != 2'h0));
  endfunction : exp_pcie

  task automatic end_sim;
    $display("comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  // a hang is cut short well beyond the expected run length
  initial begin
    #100000;
    n_mismatch++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rd(8'h3d, 8'h02);
    rd(8'h3e, 8'h00);
    rd(8'h45, 8'h00);
    rd(8'h47, 8'h02);
    chk({4'h0, intx_pin_onehot}, 8'h02);
    chk({7'h0, cpl_timeout_run}, 8'h01);
    for (k = 0; k < 3; k++) begin
      wr(ro[k], 8'hff);
      rd(ro[k], 8'h00);
    end
    // hot reset, then release and wait for the link to reach detect
    wr(8'h3e, 8'hff);
    rd(8'h3e, 8'h4f);
    chk({7'h0, ltssm_hot_reset}, 8'h01);
    wr(8'h3e, 8'h0f);
    for (i = 0; i < 40 && ltssm_enter_detect !== 1'b1; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk({7'h0, i < 40}, 8'h01);
    chk({7'h0, ltssm_hot_reset}, 8'h00);
    rd(8'h3e, 8'h0f);
    // reserved pin codes do not lock, the first good one does
    for (k = 0; k < 4; k++) begin
      wr(8'h3d, pw[k]);
      rd(8'h3d, pe[k]);
    end
    chk({4'h0, intx_pin_onehot}, 8'h08);
    wr(8'h45, 8'h0e);
    rd(8'h45, 8'h0e);
    chk({6'h0, ts_loopback_en, cpl_timeout_run}, 8'h02);
    wr(8'h45, 8'h00);
    // turn-off with a prompt and then a slow partner
    for (k = 0; k < 2; k++) begin
      ack_delay <= k ? 8'h28 : 8'h03;
      wr(8'h45, 8'h01);
      #1;
      chk({7'h0, power_off_send}, 8'h01);
      rd(8'h45, 8'h01);
      for (i = 0; i < 60 && power_off_ack_in !== 1'b1; i++) begin
        @(posedge core_clk);
        #1;
      end
      chk({7'h0, i < 60}, 8'h01);
      rd(8'h45, 8'h00);
      rd(8'h47, 8'h03);
      if (k == 0) begin
        wr(8'h47, 8'h01);
        rd(8'h47, 8'h02);
      end
    end
    // link down drops both the pending request and the ack status
    wr(8'h45, 8'h01);
    @(posedge core_clk);
    {dl_down, link_active} <= 2'b10;
    rd(8'h45, 8'h00);
    rd(8'h47, 8'h00);
    @(posedge core_clk);
    {dl_down, link_active} <= 2'b01;
    repeat (50) @(posedge core_clk);
    rd(8'h47, 8'h02);
    // random routing, error and hot swap traffic
    for (i = 0; i < 48; i++) begin
      bc = 8'($random(seed)) & 8'h0f;
      vc = 8'($random(seed)) & 8'h04;
      r = $random(seed);
      wr(8'h3e, bc);
      wr(8'h45, vc);
      b = {5'h0, r[26:16]};
      a = r[0] ? {20'h0, (i % 4 == 0) ? 12'h3b0 + {6'h0, r[6:1]} : r[12:1]} : (32'h00080000 | {13'h0, r[19:1]});
      p = exp_pcie(r[0], a, bc, b, b + {6'h0, r[31:22]});
      e = {2'h0, 1'b1, p, !p, bc[1] && (r[13] || r[15] || (r[14] && bc[0])), r[20] && !vc[2], r[20] && vc[2]};
      @(posedge core_clk);
      {cpu_req, cpu_is_io, cpu_addr, io_window_base, io_window_limit} <= {1'b1, r[0], a, b, b + {6'h0, r[31:22]}};
      {serr_msg_in, poison_tlp_in, other_err_in, hot_swap_event} <= {r[13], r[14], r[15], r[20]};
      @(posedge core_clk);
      {cpu_req, serr_msg_in, poison_tlp_in, other_err_in, hot_swap_event} <= 5'h00;
      #1;
      chk({2'h0, route_valid, route_pcie, route_hub, hub_serr, hot_swap_gpe, hot_swap_intx}, e);
    end
    end_sim();
  end
endmodule : tb_top

bind prb_bridge_ctrl prb_bridge_ctrl_assertions u_chk (.core_clk, .reset_n, .cfg_addr, .cfg_wdata, .cfg_wr,
  .cfg_rd, .cfg_rdata, .dl_down, .tx_min_met, .ltssm_hot_reset, .ltssm_enter_detect, .power_off_send,
  .ts_loopback_en, .cpl_timeout_run, .intx_pin_onehot, .cpu_req, .route_valid, .route_pcie, .route_hub,
  .serr_msg_in, .poison_tlp_in, .other_err_in, .hot_swap_event, .hub_serr, .hot_swap_gpe, .hot_swap_intx);

`default_nettype wire
